// *** design/ccs_regs.sv ***
// Purpose: Control and status register bank of a multirate data recovery receiver
// Assumes: Loop status inputs synchronous to i_clk_sys; host on the serial port
// Notes:   Software reset returns the control registers to their defaults
//
// Overview of operation
// - Status bit 4 reads 0 when locked, 1 during frequency acquisition.
// - In sticky mode, status bit 2 latches loss of lock until cleared.
// - Status bit 0 sets at measurement end, held until rate reset.
// - Mode field 000 locks to data, 010 to reference; 001, 011 reserved.
// - Writing 1 then 0 to control bit 2 clears the sticky flag.
// - Writing 1 to control bit 1 starts a fine rate measurement.
// - Writing 1 to control bit 0 clears the measurement and its flag.
// - Writing 1 then 0 to second control bit 7 resets the device.
// - Writing 1 then 0 to second control bit 6 starts frequency acquisition.
// - Reference clock stays powered down until third control bit 2 is 0.
// - Reference mode bit 6 picks reference or data for lock compare.
// - Two-bit band field picks one of four reference octave bands.
// - Four-bit ratio code gives two to the power code minus one.
`timescale 1ns/10ps
`default_nettype none
module ccs_regs
    import ccs_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = ccs_pkg::SER_DEVICE_ADDR,
    parameter logic [7:0] MAKER_HIGH  = ccs_pkg::ID_MAKER_HIGH,
    parameter logic [7:0] MAKER_LOW   = ccs_pkg::ID_MAKER_LOW,
    parameter logic [7:0] REVISION    = ccs_pkg::ID_REVISION,
    parameter logic [7:0] PART_ID     = ccs_pkg::ID_PART
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_sda,
    output var  logic       o_sda_oe,
    input  wire logic       i_lock_lost_now,
    input  wire logic       i_rate_measure_finish,
    output var  logic [2:0] o_recovery_mode_sel,
    output var  logic       o_lock_to_data_mode,
    output var  logic       o_lock_to_reference_mode,
    output var  logic       o_recovery_mode_reserved,
    output var  logic       o_recovery_bypass,
    output var  logic       o_lock_report_select,
    output var  logic       o_ref_clock_powerdown,
    output var  logic       o_lock_compare_source,
    output var  logic [1:0] o_ref_band_select,
    output var  logic [3:0] o_rate_ratio_code,
    output var  logic       o_rate_ratio_valid,
    output var  logic       o_rate_measure_start,
    output var  logic       o_rate_measure_clear,
    output var  logic       o_freq_acquire_trigger,
    output var  logic       o_soft_reset
);
    typedef struct packed {
        logic [7:0] control_first;
        logic [7:0] control_second;
        logic [7:0] control_third;
        logic [7:0] reference_mode;
        logic       sticky_lock_lost;
        logic       rate_measure_done;
        logic       rate_measure_start;
        logic       rate_measure_clear;
        logic       freq_acquire_trigger;
        logic       soft_reset;
    } ccs_regs_s;

    // Write strobe aimed at one register
    function automatic logic write_hit(input logic wr, input logic [7:0] addr,
                                       input logic [7:0] ofs);
        write_hit = wr && (addr == ofs);
    endfunction

    ccs_regs_s            r;
    ccs_regs_s            next_r;
    logic                 bus_wr;
    logic [7:0]           bus_wr_addr;
    logic [7:0]           bus_wr_data;
    logic [7:0]           bus_rd_addr;
    logic [7:0]           bus_rd_data;
    logic                 wr_first;
    logic                 wr_second;
    logic                 wr_third;
    logic                 wr_refmode;
    logic [NUM_SEQ-1:0]   seq_write;
    logic [NUM_SEQ-1:0]   seq_bit;
    logic [NUM_SEQ-1:0]   seq_fire;
    logic [7:0]           status_value;

    ccs_serial_slave #(
        .DEVICE_ADDR (DEVICE_ADDR)
    ) u_serial (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_scl     (i_scl),
        .i_sda     (i_sda),
        .o_sda     (o_sda),
        .o_sda_oe  (o_sda_oe),
        .o_wr      (bus_wr),
        .o_wr_addr (bus_wr_addr),
        .o_wr_data (bus_wr_data),
        .o_rd_addr (bus_rd_addr),
        .i_rd_data (bus_rd_data)
    );

    always_comb begin
        wr_first   = write_hit(bus_wr, bus_wr_addr, OFS_CONTROL_FIRST);
        wr_second  = write_hit(bus_wr, bus_wr_addr, OFS_CONTROL_SECOND);
        wr_third   = write_hit(bus_wr, bus_wr_addr, OFS_CONTROL_THIRD);
        wr_refmode = write_hit(bus_wr, bus_wr_addr, OFS_REFERENCE_MODE);
    end

    assign seq_write[SEQ_STICKY_CLEAR] = wr_first;
    assign seq_bit[SEQ_STICKY_CLEAR]   = bus_wr_data[BIT_STICKY_CLEAR];
    assign seq_write[SEQ_SOFT_RESET]   = wr_second;
    assign seq_bit[SEQ_SOFT_RESET]     = bus_wr_data[BIT_SOFT_RESET];
    assign seq_write[SEQ_FREQ_ACQUIRE] = wr_second;
    assign seq_bit[SEQ_FREQ_ACQUIRE]   = bus_wr_data[BIT_FREQ_ACQUIRE];

    for (genvar k = 0; k < NUM_SEQ; k++) begin : g_seq
        ccs_seq_detect u_seq (
            .i_clk_sys (i_clk_sys),
            .i_reset_n (i_reset_n),
            .i_write   (seq_write[k]),
            .i_bit     (seq_bit[k]),
            .i_disarm  (seq_fire[SEQ_SOFT_RESET]),
            .o_fire    (seq_fire[k])
        );
    end

    always_comb begin
        next_r                      = r;
        next_r.rate_measure_start   = 1'b0;
        next_r.rate_measure_clear   = 1'b0;
        next_r.freq_acquire_trigger = 1'b0;
        next_r.soft_reset           = 1'b0;
        if (seq_fire[SEQ_SOFT_RESET]) begin
            next_r.control_first     = RST_CONTROL_FIRST;
            next_r.control_second    = RST_CONTROL_SECOND;
            next_r.control_third     = RST_CONTROL_THIRD;
            next_r.reference_mode    = RST_REFERENCE_MODE;
            next_r.sticky_lock_lost  = 1'b0;
            next_r.rate_measure_done = 1'b0;
            next_r.soft_reset        = 1'b1;
        end else begin
            if (wr_first) begin
                next_r.control_first = bus_wr_data;
            end
            if (wr_second) begin
                next_r.control_second = bus_wr_data;
            end
            if (wr_third) begin
                next_r.control_third = bus_wr_data;
            end
            if (wr_refmode) begin
                next_r.reference_mode = bus_wr_data;
            end
            next_r.rate_measure_start = wr_first && bus_wr_data[BIT_RATE_START];
            next_r.rate_measure_clear = wr_first && bus_wr_data[BIT_RATE_CLEAR];
            next_r.freq_acquire_trigger = seq_fire[SEQ_FREQ_ACQUIRE];
            if (seq_fire[SEQ_STICKY_CLEAR]) begin
                next_r.sticky_lock_lost = 1'b0;
            end
            if (r.control_second[BIT_REPORT_SELECT] && i_lock_lost_now) begin
                next_r.sticky_lock_lost = 1'b1;
            end
            if (wr_first && bus_wr_data[BIT_RATE_CLEAR]) begin
                next_r.rate_measure_done = 1'b0;
            end
            if (i_rate_measure_finish) begin
                next_r.rate_measure_done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r                <= '0;
            r.control_first  <= RST_CONTROL_FIRST;
            r.control_second <= RST_CONTROL_SECOND;
            r.control_third  <= RST_CONTROL_THIRD;
            r.reference_mode <= RST_REFERENCE_MODE;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        status_value = 8'h00;
        status_value[BIT_LOCK_LOST_NOW]    = i_lock_lost_now;
        status_value[BIT_STICKY_LOCK_LOST] = r.sticky_lock_lost;
        status_value[BIT_RATE_DONE]        = r.rate_measure_done;
        case (bus_rd_addr)
            OFS_LOCK_STATUS:    bus_rd_data = status_value;
            OFS_CONTROL_FIRST:  bus_rd_data = r.control_first;
            OFS_CONTROL_SECOND: bus_rd_data = r.control_second;
            OFS_CONTROL_THIRD:  bus_rd_data = r.control_third;
            OFS_REFERENCE_MODE: bus_rd_data = r.reference_mode;
            OFS_MAKER_HIGH:     bus_rd_data = MAKER_HIGH;
            OFS_MAKER_LOW:      bus_rd_data = MAKER_LOW;
            OFS_REVISION:       bus_rd_data = REVISION;
            OFS_PART_ID:        bus_rd_data = PART_ID;
            default:            bus_rd_data = READ_UNMAPPED;
        endcase
    end

    assign o_recovery_mode_sel      = r.control_first[MODE_LSB +: MODE_W];
    assign o_lock_to_data_mode      = (o_recovery_mode_sel == MODE_LOCK_DATA);
    assign o_lock_to_reference_mode = (o_recovery_mode_sel == MODE_LOCK_REF);
    assign o_recovery_mode_reserved = !o_lock_to_data_mode && !o_lock_to_reference_mode;
    assign o_recovery_bypass        = r.control_second[BIT_BYPASS];
    assign o_lock_report_select     = r.control_second[BIT_REPORT_SELECT];
    assign o_ref_clock_powerdown    = r.control_third[BIT_REF_POWERDOWN];
    assign o_lock_compare_source    = r.reference_mode[BIT_COMPARE_SOURCE];
    assign o_ref_band_select        = r.reference_mode[BAND_LSB +: BAND_W];
    assign o_rate_ratio_code        = r.reference_mode[RATIO_LSB +: RATIO_W];
    assign o_rate_ratio_valid       = (o_rate_ratio_code <= RATIO_MAX_CODE);
    assign o_rate_measure_start     = r.rate_measure_start;
    assign o_rate_measure_clear     = r.rate_measure_clear;
    assign o_freq_acquire_trigger   = r.freq_acquire_trigger;
    assign o_soft_reset             = r.soft_reset;
endmodule // ccs_regs
`default_nettype wire

// *** design/ccs_pkg.sv ***
// Purpose: Shared constants for the recovery control and status register bank
// Assumes: Byte-wide registers behind a two-wire serial management port
// Notes:   Offsets are byte register addresses on the serial port
package ccs_pkg;

    // Register offsets
    localparam logic [7:0] OFS_LOCK_STATUS    = 8'h06;
    localparam logic [7:0] OFS_CONTROL_FIRST  = 8'h08;
    localparam logic [7:0] OFS_CONTROL_SECOND = 8'h09;
    localparam logic [7:0] OFS_CONTROL_THIRD  = 8'h0a;
    localparam logic [7:0] OFS_REFERENCE_MODE = 8'h0f;
    localparam logic [7:0] OFS_MAKER_HIGH     = 8'h20;
    localparam logic [7:0] OFS_MAKER_LOW      = 8'h21;
    localparam logic [7:0] OFS_REVISION       = 8'h48;
    localparam logic [7:0] OFS_PART_ID        = 8'h49;

    // Reset values and unmapped read value
    localparam logic [7:0] RST_CONTROL_FIRST  = 8'h10;
    localparam logic [7:0] RST_CONTROL_SECOND = 8'h08;
    localparam logic [7:0] RST_CONTROL_THIRD  = 8'h05;
    localparam logic [7:0] RST_REFERENCE_MODE = 8'h00;
    localparam logic [7:0] READ_UNMAPPED      = 8'h00;

    // Identity defaults, values arbitrary
    localparam logic [7:0] ID_MAKER_HIGH      = 8'h5a;
    localparam logic [7:0] ID_MAKER_LOW       = 8'h3c;
    localparam logic [7:0] ID_REVISION        = 8'h01;
    localparam logic [7:0] ID_PART            = 8'h42;

    // Status field positions
    localparam int BIT_LOCK_LOST_NOW     = 4;
    localparam int BIT_STICKY_LOCK_LOST  = 2;
    localparam int BIT_RATE_DONE         = 0;

    // First control field positions
    localparam int MODE_LSB              = 4;
    localparam int MODE_W                = 3;
    localparam int BIT_STICKY_CLEAR      = 2;
    localparam int BIT_RATE_START        = 1;
    localparam int BIT_RATE_CLEAR        = 0;

    // Second control field positions
    localparam int BIT_SOFT_RESET        = 7;
    localparam int BIT_FREQ_ACQUIRE      = 6;
    localparam int BIT_BYPASS            = 5;
    localparam int BIT_REPORT_SELECT     = 4;

    // Third control field positions
    localparam int BIT_REF_POWERDOWN     = 2;

    // Reference mode field positions
    localparam int BIT_COMPARE_SOURCE    = 6;
    localparam int BAND_LSB              = 4;
    localparam int BAND_W                = 2;
    localparam int RATIO_LSB             = 0;
    localparam int RATIO_W               = 4;

    // Mode and ratio codes
    localparam logic [2:0] MODE_LOCK_DATA = 3'h0;
    localparam logic [2:0] MODE_LOCK_REF  = 3'h2;
    localparam logic [3:0] RATIO_MAX_CODE = 4'ha;

    // Write-one-then-zero sequence slots
    localparam int NUM_SEQ               = 3;
    localparam int SEQ_STICKY_CLEAR      = 0;
    localparam int SEQ_SOFT_RESET        = 1;
    localparam int SEQ_FREQ_ACQUIRE      = 2;

    // Serial port
    localparam int         SER_ADDR_W       = 7;
    localparam logic [6:0] SER_DEVICE_ADDR  = 7'h40;
    localparam logic [3:0] SER_BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        SER_IDLE,
        SER_RECV,
        SER_ACK,
        SER_SEND,
        SER_SEND_ACK
    } ccs_ser_state_e;

    typedef enum logic [1:0] {
        PH_DEVICE,
        PH_POINTER,
        PH_DATA
    } ccs_ser_phase_e;

endpackage

// *** design/ccs_seq_detect.sv ***
// Purpose: Fires once when a bit is written one and then written zero
// Assumes: i_write marks each write to the register holding the bit
// Notes:   Pulse appears the cycle after the zero write
`timescale 1ns/10ps
`default_nettype none
module ccs_seq_detect (
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_write,
    input  wire logic i_bit,
    input  wire logic i_disarm,
    output var  logic o_fire
);
    typedef struct packed {
        logic armed;
        logic fire;
    } ccs_seq_s;

    ccs_seq_s state;
    ccs_seq_s next_state;

    always_comb begin
        next_state      = state;
        next_state.fire = 1'b0;
        if (i_disarm) begin
            next_state.armed = 1'b0;
        end else if (i_write && i_bit) begin
            next_state.armed = 1'b1;
        end else if (i_write && state.armed) begin
            next_state.armed = 1'b0;
            next_state.fire  = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_fire = state.fire;
endmodule // ccs_seq_detect
`default_nettype wire

// *** design/ccs_serial_slave.sv ***
// Purpose: Two-wire serial management slave with byte register pointer
// Assumes: Clock and data pins already synchronous to i_clk_sys
// Notes:   Pointer auto-increments after each data byte
`timescale 1ns/10ps
`default_nettype none
module ccs_serial_slave
    import ccs_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = ccs_pkg::SER_DEVICE_ADDR
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_sda,
    output var  logic       o_sda_oe,
    output var  logic       o_wr,
    output var  logic [7:0] o_wr_addr,
    output var  logic [7:0] o_wr_data,
    output var  logic [7:0] o_rd_addr,
    input  wire logic [7:0] i_rd_data
);
    typedef struct packed {
        logic           scl_q;
        logic           sda_q;
        ccs_ser_state_e st;
        ccs_ser_phase_e ph;
        logic           rnw;
        logic           nack;
        logic [3:0]     bitcnt;
        logic [7:0]     shreg;
        logic [7:0]     ptr;
        logic           wr;
        logic [7:0]     wr_addr;
        logic [7:0]     wr_data;
    } ccs_ser_s;

    ccs_ser_s s;
    ccs_ser_s next_s;
    logic     scl_rise;
    logic     scl_fall;
    logic     start_cond;
    logic     stop_cond;

    always_comb begin
        scl_rise   = i_scl && !s.scl_q;
        scl_fall   = !i_scl && s.scl_q;
        start_cond = i_scl && s.scl_q && s.sda_q && !i_sda;
        stop_cond  = i_scl && s.scl_q && !s.sda_q && i_sda;
        next_s       = s;
        next_s.scl_q = i_scl;
        next_s.sda_q = i_sda;
        next_s.wr    = 1'b0;
        if (start_cond) begin
            next_s.st     = SER_RECV;
            next_s.ph     = PH_DEVICE;
            next_s.bitcnt = 4'h0;
        end else if (stop_cond) begin
            next_s.st = SER_IDLE;
        end else begin
            case (s.st)
                SER_RECV: begin
                    if (scl_rise) begin
                        next_s.shreg  = {s.shreg[6:0], i_sda};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (scl_fall && s.bitcnt == SER_BITS_PER_BYTE) begin
                        next_s.st = SER_ACK;
                        case (s.ph)
                            PH_DEVICE: begin
                                next_s.rnw = s.shreg[0];
                                if (s.shreg[7:1] != DEVICE_ADDR) begin
                                    next_s.st = SER_IDLE;
                                end
                            end
                            PH_POINTER: begin
                                next_s.ptr = s.shreg;
                            end
                            default: begin
                                next_s.wr      = 1'b1;
                                next_s.wr_addr = s.ptr;
                                next_s.wr_data = s.shreg;
                                next_s.ptr     = s.ptr + 8'h01;
                            end
                        endcase
                    end
                end
                SER_ACK: begin
                    if (scl_fall) begin
                        next_s.bitcnt = 4'h0;
                        if (s.rnw && s.ph == PH_DEVICE) begin
                            next_s.st    = SER_SEND;
                            next_s.shreg = i_rd_data;
                            next_s.ptr   = s.ptr + 8'h01;
                        end else begin
                            next_s.st = SER_RECV;
                            next_s.ph = (s.ph == PH_DEVICE) ? PH_POINTER : PH_DATA;
                        end
                    end
                end
                SER_SEND: begin
                    if (scl_fall) begin
                        next_s.shreg  = {s.shreg[6:0], 1'b1};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                        if (s.bitcnt == SER_BITS_PER_BYTE - 4'h1) begin
                            next_s.st = SER_SEND_ACK;
                        end
                    end
                end
                SER_SEND_ACK: begin
                    if (scl_rise) begin
                        next_s.nack = i_sda;
                    end else if (scl_fall) begin
                        if (s.nack) begin
                            next_s.st = SER_IDLE;
                        end else begin
                            next_s.st     = SER_SEND;
                            next_s.bitcnt = 4'h0;
                            next_s.shreg  = i_rd_data;
                            next_s.ptr    = s.ptr + 8'h01;
                        end
                    end
                end
                default: begin
                    next_s.st = SER_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s       <= '0;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
            s.st    <= SER_IDLE;
            s.ph    <= PH_DEVICE;
        end else begin
            s <= next_s;
        end
    end

    // Open drain: only ever pulls low
    assign o_sda     = 1'b0;
    assign o_sda_oe  = (s.st == SER_ACK) || (s.st == SER_SEND && !s.shreg[7]);
    assign o_wr      = s.wr;
    assign o_wr_addr = s.wr_addr;
    assign o_wr_data = s.wr_data;
    assign o_rd_addr = s.ptr;
endmodule // ccs_serial_slave
`default_nettype wire

// *** verification/ccs_regs_chk.sv ***
// Purpose: Port assertions for the register bank
// Assumes: One clock, async active-low reset
// Notes:   Bound to ccs_regs from the bench top
`timescale 1ns/10ps
`default_nettype none
module ccs_regs_chk (
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    input wire logic [2:0] o_recovery_mode_sel,
    input wire logic       o_lock_to_data_mode,
    input wire logic       o_lock_to_reference_mode,
    input wire logic       o_recovery_mode_reserved,
    input wire logic [3:0] o_rate_ratio_code,
    input wire logic       o_rate_ratio_valid,
    input wire logic       o_rate_measure_start,
    input wire logic       o_freq_acquire_trigger,
    input wire logic       o_soft_reset,
    input wire logic       o_ref_clock_powerdown,
    input wire logic       o_recovery_bypass,
    input wire logic       o_lock_report_select
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_drop(x);
        x ##1 !x;
    endsequence
    sequence s_dflt;
        o_ref_clock_powerdown && o_recovery_mode_sel == 3'h1 && o_rate_ratio_code == 4'h0;
    endsequence
    chk_mode_data: assert property (
        o_lock_to_data_mode == (o_recovery_mode_sel == 3'h0)) else $error("data mode");
    chk_mode_ref: assert property (
        o_lock_to_reference_mode == (o_recovery_mode_sel == 3'h2)) else $error("ref mode");
    chk_mode_rsv: assert property (
        o_recovery_mode_reserved == (o_recovery_mode_sel != 3'h0 && o_recovery_mode_sel != 3'h2))
        else $error("reserved mode");
    chk_ratio_valid: assert property (
        o_rate_ratio_valid == (o_rate_ratio_code <= 4'ha)) else $error("ratio valid");
    chk_start_pulse: assert property (
        o_rate_measure_start |-> s_drop(o_rate_measure_start)) else $error("start pulse");
    chk_acq_pulse: assert property (
        o_freq_acquire_trigger |-> s_drop(o_freq_acquire_trigger)) else $error("acq pulse");
    chk_soft_dflt: assert property (
        o_soft_reset |=> s_dflt ##0 !o_recovery_bypass && !o_lock_report_select)
        else $error("soft reset defaults");
    chk_reset_pdn: assert property (
        $rose(i_reset_n) |-> s_dflt) else $error("powerdown at reset");
endmodule // ccs_regs_chk
`default_nettype wire

// *** verification/ccs_host_model.sv ***
// Purpose: Serial management host for the register bank
// Assumes: Data line resolved with pull-up outside
// Notes:   hp sets each clock phase length
`timescale 1ns/10ps
`default_nettype none
module ccs_host_model
    import ccs_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda_oe
);
    int   hp  = 2;
    logic nak = 1'b0;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic xb(input logic b, output logic r);
        cyc(1);
        o_sda_oe = !b;
        cyc(hp - 1);
        o_scl = 1'b1;
        cyc(hp);
        r = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, input logic ck);
        logic a;
        for (int i = 7; i >= 0; i--) xb(d[i], q[i]);
        xb(1'b1, a);
        if (ck) nak = nak | a;
    endtask
    // Start when f is 0, stop when f is 1
    task automatic frame(input logic f);
        cyc(1);
        o_sda_oe = f;
        cyc(1);
        o_scl = 1'b1;
        cyc(hp);
        o_sda_oe = !f;
        cyc(hp);
        o_scl = f;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        frame(1'b0);
        xbyte({SER_DEVICE_ADDR, 1'b0}, q, 1'b1);
        xbyte(a, q, 1'b1);
        xbyte(d, q, 1'b1);
        frame(1'b1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        frame(1'b0);
        xbyte({SER_DEVICE_ADDR, 1'b0}, q, 1'b1);
        xbyte(a, q, 1'b1);
        frame(1'b0);
        xbyte({SER_DEVICE_ADDR, 1'b1}, q, 1'b1);
        xbyte(8'hff, q, 1'b0);
        frame(1'b1);
    endtask
endmodule // ccs_host_model
`default_nettype wire

// *** verification/tb_cdr_control_status_regs.sv ***
// Purpose: Self-checking bench for the register bank
// Assumes: Host model drives the serial port
// Notes:   Reference mode values come from an LFSR after two fixed values
`timescale 1ns/10ps
`default_nettype none
module tb_cdr_control_status_regs;
    import ccs_pkg::*;
    logic       i_clk_sys = 1'b0;
    logic       i_reset_n = 1'b0;
    logic       lost = 1'b0;
    logic       fin = 1'b0;
    logic [2:0] mode;
    logic [1:0] band;
    logic [3:0] ratio;
    logic       src, pdn, st, acq, srst, scl, h_oe, d_oe, clr;
    logic [7:0] n_st = 8'h00, n_acq = 8'h00, n_sr = 8'h00, q, v;
    logic [31:0] r = 32'hf734e6ce;
    int         err_count = 0;
    int         n_checks = 0;
    logic [7:0] offs [9] = '{8'h08, 8'h09, 8'h0a, 8'h0f, 8'h20, 8'h21, 8'h48, 8'h49, 8'h30};
    logic [7:0] dflt [9] = '{8'h10, 8'h08, 8'h05, 8'h00, 8'h5a, 8'h3c, 8'h01, 8'h42, 8'h00};
    wire logic  sda = !(h_oe || d_oe);
    always #20 i_clk_sys = !i_clk_sys;
    always @(posedge i_clk_sys) begin
        n_st <= n_st + 8'(st);
        n_acq <= n_acq + 8'(acq);
        n_sr <= n_sr + 8'(srst) + 8'(clr);
    end
    ccs_host_model i_host (.i_clk_sys, .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
    ccs_regs i_dut (.i_clk_sys, .i_reset_n, .i_scl(scl), .i_sda(sda), .o_sda(),
        .o_sda_oe(d_oe), .i_lock_lost_now(lost), .i_rate_measure_finish(fin),
        .o_recovery_mode_sel(mode), .o_lock_to_data_mode(), .o_lock_to_reference_mode(),
        .o_recovery_mode_reserved(), .o_recovery_bypass(), .o_lock_report_select(),
        .o_ref_clock_powerdown(pdn), .o_lock_compare_source(src), .o_ref_band_select(band),
        .o_rate_ratio_code(ratio), .o_rate_ratio_valid(), .o_rate_measure_start(st),
        .o_rate_measure_clear(clr), .o_freq_acquire_trigger(acq), .o_soft_reset(srst));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            err_count++;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, q);
        chk("register read", e, q);
    endtask
    function automatic logic [7:0] stat(input logic l, input logic s, input logic d);
        return {3'h0, l, 1'h0, s, 1'h0, d};
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        i_host.cyc(2);
        i_host.wr(8'h48, 8'hff);
        i_host.wr(8'h30, 8'hff);
        for (int i = 0; i < 9; i++) rchk(offs[i], dflt[i]);
        chk("powerdown", 8'h01, {7'h0, pdn});
        for (int c = 0; c < 4; c++) begin
            i_host.wr(8'h08, {1'b0, 3'(c), 4'h0});
            chk("mode", {5'h0, 3'(c)}, {5'h0, mode});
        end
        for (int k = 0; k < 8; k++) begin
            r = lfsr(r);
            v = (k == 0) ? 8'h3a : (k == 1) ? 8'h7f : {1'b0, r[6:0]};
            i_host.wr(8'h0f, v);
            rchk(8'h0f, v);
            chk("ref fields", v, {1'b0, src, band, ratio});
        end
        i_host.wr(8'h08, 8'h02);
        chk("start pulses", 8'h01, n_st);
        fin = 1'b1;
        i_host.cyc(1);
        fin = 1'b0;
        rchk(8'h06, stat(1'b0, 1'b0, 1'b1));
        i_host.wr(8'h08, 8'h01);
        rchk(8'h06, stat(1'b0, 1'b0, 1'b0));
        i_host.wr(8'h09, 8'h18);
        lost = 1'b1;
        rchk(8'h06, stat(1'b1, 1'b1, 1'b0));
        lost = 1'b0;
        i_host.wr(8'h08, 8'h04);
        rchk(8'h06, stat(1'b0, 1'b1, 1'b0));
        i_host.wr(8'h08, 8'h00);
        rchk(8'h06, stat(1'b0, 1'b0, 1'b0));
        i_host.hp = 4;
        i_host.wr(8'h09, 8'h58);
        i_host.wr(8'h09, 8'h18);
        chk("acquire pulses", 8'h01, n_acq);
        i_host.wr(8'h0a, 8'h01);
        chk("powerdown", 8'h00, {7'h0, pdn});
        i_host.wr(8'h09, 8'hb8);
        i_host.wr(8'h09, 8'h38);
        chk("reset pulses", 8'h02, n_sr);
        for (int i = 0; i < 4; i++) rchk(offs[i], dflt[i]);
        chk("host acks", 8'h00, {7'h0, i_host.nak});
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        err_count++;
        end_of_test();
    end
endmodule // tb_cdr_control_status_regs
bind ccs_regs ccs_regs_chk i_chk (.i_clk_sys, .i_reset_n, .o_recovery_mode_sel,
    .o_lock_to_data_mode, .o_lock_to_reference_mode, .o_recovery_mode_reserved,
    .o_rate_ratio_code, .o_rate_ratio_valid, .o_rate_measure_start,
    .o_freq_acquire_trigger, .o_soft_reset, .o_ref_clock_powerdown,
    .o_recovery_bypass, .o_lock_report_select);
`default_nettype wire
